// ==== core/sdma_pkg.sv ====
// Purpose: constants and carriers for the serial DMA control and status.
// Assumes: one system clock; byte addresses on the register bus.
// Notes:   index 0 is serial controller 1, index 1 is serial controller 2.
package sdma_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int unsigned  NUM_INST         = 2;
    localparam logic [31:0]  SER1_STATUS_ADDR = 32'h4000_C82C;
    localparam logic [31:0]  SER1_CTRL_ADDR   = 32'h4000_C830;
    localparam logic [31:0]  SER2_STATUS_ADDR = 32'h4000_C02C;
    localparam logic [31:0]  SER2_CTRL_ADDR   = 32'h4000_C030;
    localparam logic [31:0]  CTRL_RESET_VAL   = 32'h0000_0000;
    localparam logic [31:0]  STATUS_RESET_VAL = 32'h0000_0000;
    localparam logic [31:0]  UNMAPPED_VAL     = 32'h0000_0000;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned  CTRL_TX_RST_BIT  = 5;
    localparam int unsigned  CTRL_RX_RST_BIT  = 4;
    localparam int unsigned  CTRL_TX_LD_LSB   = 2;
    localparam int unsigned  CTRL_RX_LD_LSB   = 0;
    localparam int unsigned  STAT_SSEL_LSB    = 10;
    localparam int unsigned  STAT_FRM_LSB     = 8;
    localparam int unsigned  STAT_PAR_LSB     = 6;
    localparam int unsigned  STAT_OVF_LSB     = 4;
    localparam int unsigned  STAT_TX_ACT_LSB  = 2;
    localparam int unsigned  STAT_RX_ACT_LSB  = 0;

    // ************************************************************
    // count-save codes, buffer select
    // ************************************************************
    localparam logic [2:0]   SSEL_NONE        = 3'h0;
    localparam logic [2:0]   SSEL_ONCE        = 3'h2;
    localparam logic [2:0]   SSEL_MULTI       = 3'h6;
    localparam logic         BUF_A            = 1'b0;
    localparam logic         BUF_B            = 1'b1;

    // events from the transfer engine and serial controller
    typedef struct packed {
        logic [1:0] tx_unload;
        logic [1:0] rx_unload;
        logic       rx_byte;
        logic       rx_frame_err;
        logic       rx_parity_err;
        logic       rx_overrun;
        logic       ssel_deassert;
        logic       spi_slave_mode;
        logic       uart_mode;
    } sdma_evt_type;

    // commands and status toward the transfer engine
    typedef struct packed {
        logic [1:0] tx_active;
        logic [1:0] rx_active;
        logic [1:0] tx_load;
        logic [1:0] rx_load;
        logic       tx_reset;
        logic       rx_reset;
    } sdma_chan_out_type;

endpackage

// ==== core/sdma_ctrl.sv ====
// Purpose: DMA control/status registers for two serial controllers.
// Assumes: Avalon-MM slave, byte addresses, one clock, sync reset.
// Notes:   bit [1] of every buffer pair is buffer B, bit [0] buffer A.
//
// What this block does
// - writing transmit reset resets channel, self-clears
// - writing receive reset resets channel, self-clears
// - transmit load bits 3/2 start buffer B/A
// - receive load bits 1/0 start buffer B/A
// - simultaneous load of both runs A first
// - load bit clears on unload; zero writes ignored
// - load bit reads one while active or pending
// - count-save field 12:10, zero when no deassert
// - single deassert gives 2 for A, 3 for B
// - repeated deassert gives 6/7; never 1,4,5
// - count-save clears on receive load or reset
// - buffer B framing error flag, bit 9
// - buffer A framing error flag, bit 8
// - buffer B parity error flag, bit 7
// - framing/parity flags only instance 0 in UART mode
// - separate control/status per instance, reset zero
// - buffer A parity error flag, bit 6
// - overrun flags bits 5/4 on draining buffer
// - status bits 3/2 show active transmit buffer
// - status bits 1/0 show active receive buffer
//
// The Avalon-MM slave port was chosen for this implementation.
module sdma_ctrl
(
    input  wire logic                            clk_i,
    input  wire logic                            reset_i,
    input  wire logic [31:0]                     address_i,
    input  wire logic                            read_i,
    input  wire logic                            write_i,
    input  wire logic [31:0]                     writedata_i,
    input  wire logic [3:0]                      byteenable_i,
    output logic      [31:0]                     readdata_o,
    output logic                                 waitrequest_o,
    input  wire sdma_pkg::sdma_evt_type [1:0]    evt_i,
    output sdma_pkg::sdma_chan_out_type [1:0]    chan_o
);
    import sdma_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [1:0] tx_ld;
        logic       tx_sel;
        logic [1:0] rx_ld;
        logic       rx_sel;
        logic [2:0] ssel;
        logic [1:0] frm;
        logic [1:0] par;
        logic [1:0] ovf;
    } sdma_inst_type;

    typedef struct packed {
        logic                           waitrequest;
        logic [31:0]                    readdata;
        sdma_inst_type [1:0]            inst;
        sdma_chan_out_type [1:0]        chan;
    } sdma_state_type;

    typedef struct packed {
        logic       hit;
        logic       is_ctrl;
        logic       idx;
    } sdma_dec_type;

    sdma_state_type state_reg;
    sdma_state_type state_next;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic sdma_dec_type decode(input logic [31:0] addr);
        sdma_dec_type d;
        d = '0;
        if (addr == SER1_CTRL_ADDR)
        begin
            d = '{hit: 1'b1, is_ctrl: 1'b1, idx: 1'b0};
        end
        else if (addr == SER1_STATUS_ADDR)
        begin
            d = '{hit: 1'b1, is_ctrl: 1'b0, idx: 1'b0};
        end
        else if (addr == SER2_CTRL_ADDR)
        begin
            d = '{hit: 1'b1, is_ctrl: 1'b1, idx: 1'b1};
        end
        else if (addr == SER2_STATUS_ADDR)
        begin
            d = '{hit: 1'b1, is_ctrl: 1'b0, idx: 1'b1};
        end
        return d;
    endfunction

    // load bits and buffer pointer of one channel for the next cycle
    function automatic logic [2:0] chan_step(
        input logic [1:0] ld,
        input logic       sel,
        input logic [1:0] load,
        input logic [1:0] unload,
        input logic       rst
    );
        logic [1:0] ld_n;
        logic       sel_n;
        ld_n  = ld;
        sel_n = sel;
        if (rst)
        begin
            ld_n  = 2'b00;
            sel_n = BUF_A;
        end
        else if (unload[sel] && ld[sel])
        begin
            ld_n[sel] = 1'b0;
            sel_n     = ~sel;
        end
        ld_n = ld_n | load;
        if (ld_n[sel_n] == 1'b0 || ld_n == 2'b11 && ld == 2'b00)
        begin
            sel_n = ld_n[BUF_A] ? BUF_A : BUF_B;
        end
        return {ld_n, sel_n};
    endfunction

    function automatic logic [31:0] read_word(
        input sdma_dec_type      d,
        input sdma_inst_type     s,
        input sdma_chan_out_type c
    );
        logic [31:0] w;
        w = UNMAPPED_VAL;
        if (d.hit && d.is_ctrl)
        begin
            w[CTRL_TX_LD_LSB +: 2] = s.tx_ld;
            w[CTRL_RX_LD_LSB +: 2] = s.rx_ld;
        end
        else if (d.hit)
        begin
            w[STAT_SSEL_LSB +: 3]   = s.ssel;
            w[STAT_FRM_LSB +: 2]    = s.frm;
            w[STAT_PAR_LSB +: 2]    = s.par;
            w[STAT_OVF_LSB +: 2]    = s.ovf;
            w[STAT_TX_ACT_LSB +: 2] = c.tx_active;
            w[STAT_RX_ACT_LSB +: 2] = c.rx_active;
        end
        return w;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        sdma_dec_type  dec;
        logic          commit;
        logic          wr_ctrl;
        logic [1:0]    ld_tx;
        logic [1:0]    ld_rx;
        logic          rst_tx;
        logic          rst_rx;
        logic [2:0]    tx_r;
        logic [2:0]    rx_r;
        logic          rx_on;
        logic          rx_buf;
        logic          err_ok;
        sdma_inst_type s;
        dec     = decode(address_i);
        commit  = write_i && !state_reg.waitrequest;
        wr_ctrl = 1'b0;
        ld_tx   = 2'b00;
        ld_rx   = 2'b00;
        rst_tx  = 1'b0;
        rst_rx  = 1'b0;
        tx_r    = '0;
        rx_r    = '0;
        rx_on   = 1'b0;
        rx_buf  = BUF_A;
        err_ok  = 1'b0;
        s       = '0;

        state_next             = state_reg;
        state_next.waitrequest = 1'b1;
        state_next.readdata    = '0;
        if ((read_i || write_i) && state_reg.waitrequest)
        begin
            state_next.waitrequest = 1'b0;
            if (read_i)
            begin
                state_next.readdata = read_word(dec,
                    state_reg.inst[dec.idx], state_reg.chan[dec.idx]);
            end
        end

        for (int i = 0; i < NUM_INST; i++)
        begin
            s       = state_reg.inst[i];
            // status writes fall through untouched
            wr_ctrl = commit && dec.hit && dec.is_ctrl
                      && dec.idx == i[0] && byteenable_i[0];
            if (wr_ctrl)
            begin
                ld_tx  = writedata_i[CTRL_TX_LD_LSB +: 2];
                ld_rx  = writedata_i[CTRL_RX_LD_LSB +: 2];
                rst_tx = writedata_i[CTRL_TX_RST_BIT];
                rst_rx = writedata_i[CTRL_RX_RST_BIT];
            end
            else
            begin
                ld_tx  = 2'b00;
                ld_rx  = 2'b00;
                rst_tx = 1'b0;
                rst_rx = 1'b0;
            end

            // events belong to the buffer active before this edge
            rx_buf = s.rx_sel;
            rx_on  = s.rx_ld[s.rx_sel];
            err_ok = (i == 0) && evt_i[i].uart_mode;

            tx_r = chan_step(s.tx_ld, s.tx_sel, ld_tx,
                             evt_i[i].tx_unload, rst_tx);
            rx_r = chan_step(s.rx_ld, s.rx_sel, ld_rx,
                             evt_i[i].rx_unload, rst_rx);

            // count-save; a load clears, a same-cycle deassert wins
            if (rst_rx || ld_rx != 2'b00)
            begin
                s.ssel = SSEL_NONE;
            end
            if (!rst_rx && rx_on && evt_i[i].ssel_deassert
                && evt_i[i].spi_slave_mode)
            begin
                if (s.ssel == SSEL_NONE)
                begin
                    s.ssel = SSEL_ONCE | {2'b00, rx_buf};
                end
                else
                begin
                    s.ssel = SSEL_MULTI | {2'b00, rx_buf};
                end
            end

            // error flags: cleared by own load, set wins
            s.frm = s.frm & ~ld_rx;
            s.par = s.par & ~ld_rx;
            s.ovf = s.ovf & ~ld_rx;
            if (rst_rx)
            begin
                s.frm = 2'b00;
                s.par = 2'b00;
                s.ovf = 2'b00;
            end
            else if (rx_on && evt_i[i].rx_byte)
            begin
                if (err_ok && evt_i[i].rx_frame_err)
                begin
                    s.frm[rx_buf] = 1'b1;
                end
                if (err_ok && evt_i[i].rx_parity_err)
                begin
                    s.par[rx_buf] = 1'b1;
                end
                if (evt_i[i].rx_overrun)
                begin
                    s.ovf[rx_buf] = 1'b1;
                end
            end

            s.tx_ld  = tx_r[2:1];
            s.tx_sel = tx_r[0];
            s.rx_ld  = rx_r[2:1];
            s.rx_sel = rx_r[0];
            state_next.inst[i] = s;

            state_next.chan[i].tx_reset  = rst_tx;
            state_next.chan[i].rx_reset  = rst_rx;
            state_next.chan[i].tx_load   = ld_tx;
            state_next.chan[i].rx_load   = ld_rx;
            state_next.chan[i].tx_active =
                s.tx_ld & (s.tx_sel ? 2'b10 : 2'b01);
            state_next.chan[i].rx_active =
                s.rx_ld & (s.rx_sel ? 2'b10 : 2'b01);
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_reg             <= '0;
            state_reg.waitrequest <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign readdata_o    = state_reg.readdata;
    assign waitrequest_o = state_reg.waitrequest;
    assign chan_o        = state_reg.chan;

endmodule

// ==== sim/sdma_far_model.sv ====
// Purpose: far side: transfer engine and serial controller events.
// Assumes: bench commands one cycle ahead; one clock.
// Notes:   slow_i adds one cycle of latency to every event; unloads are
//          passed as commanded, so stale ones reach the block too.
module sdma_far_model
(
    input  wire logic                         clk_i,
    input  wire logic                         reset_i,
    input  wire logic                         slow_i,
    input  wire sdma_pkg::sdma_evt_type [1:0] cmd_i,
    output sdma_pkg::sdma_evt_type [1:0]      evt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import sdma_pkg::*;
    sdma_evt_type [1:0] held_reg;
    always_ff @(posedge clk_i)
    begin
        held_reg <= reset_i ? '0 : cmd_i;
        evt_o    <= reset_i ? '0 : (slow_i ? held_reg : cmd_i);
    end
endmodule

// ==== sim/sdma_ctrl_chk.sv ====
// Purpose: concurrent checks on the serial DMA control/status ports.
// Assumes: one clock, sync reset, one wait state per request.
// Notes:   instance 0 checked in depth, instance 1 for reset and load.
module sdma_ctrl_chk
(
    input wire logic                              clk_i,
    input wire logic                              reset_i,
    input wire logic [31:0]                       address_i,
    input wire logic                              read_i,
    input wire logic                              write_i,
    input wire logic [31:0]                       writedata_i,
    input wire logic [3:0]                        byteenable_i,
    input wire logic [31:0]                       readdata_o,
    input wire logic                              waitrequest_o,
    input wire sdma_pkg::sdma_evt_type [1:0]      evt_i,
    input wire sdma_pkg::sdma_chan_out_type [1:0] chan_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import sdma_pkg::*;
    logic c0;
    logic c1;
    assign c0 = write_i && !waitrequest_o && byteenable_i[0]
                && address_i == SER1_CTRL_ADDR;
    assign c1 = write_i && !waitrequest_o && byteenable_i[0]
                && address_i == SER2_CTRL_ADDR;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    tx_rst_pulse_a: assert property (
        c0 && writedata_i[5] |=> chan_o[0].tx_reset)
        else $error("transmit reset pulse missing");
    rx_rst_pulse_a: assert property (
        c1 && writedata_i[4] |=> chan_o[1].rx_reset)
        else $error("receive reset pulse missing");
    rst_clears_a: assert property (
        chan_o[0].rx_reset && !chan_o[0].rx_load
        |-> chan_o[0].rx_active == 2'b00)
        else $error("receive reset left a buffer active");
    tx_load_a: assert property (
        c0 |=> chan_o[0].tx_load == $past(writedata_i[3:2]))
        else $error("transmit load pulse wrong");
    rx_load_a: assert property (
        c0 |=> chan_o[0].rx_load == $past(writedata_i[1:0]))
        else $error("receive load pulse wrong");
    rx_load_two_a: assert property (
        c1 |=> chan_o[1].rx_load == $past(writedata_i[1:0]))
        else $error("second instance load pulse wrong");
    idle_load_a: assert property (
        !c0 |=> chan_o[0].rx_load == 2'b00 && chan_o[0].tx_load == 2'b00)
        else $error("load pulse without a write");
    a_first_a: assert property (
        chan_o[0].rx_load == 2'b11 && $past(chan_o[0].rx_active) == 2'b00
        |-> chan_o[0].rx_active == 2'b01)
        else $error("buffer B started before A");
    one_active_a: assert property (
        $onehot0(chan_o[0].rx_active) && $onehot0(chan_o[0].tx_active))
        else $error("two buffers active at once");
    rx_unload_a: assert property (
        evt_i[0].rx_unload[0] && chan_o[0].rx_active[0] && !c0
        |=> !chan_o[0].rx_active[0])
        else $error("unloaded buffer still active");
    wait_one_a: assert property (
        (read_i || write_i) && waitrequest_o
        |=> !waitrequest_o ##1 waitrequest_o)
        else $error("wait state count wrong");
    rdata_idle_a: assert property (waitrequest_o |-> readdata_o == 32'h0)
        else $error("read data outside answer");
    cover property (chan_o[0].rx_load == 2'b11);
    cover property (chan_o[0].rx_reset);
    cover property (evt_i[0].rx_unload != 2'b00 && chan_o[0].rx_active != 2'b00);
endmodule

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the serial DMA control/status.
// Assumes: far-side model drives the events.
// Notes:   expected read data queued by the driver, checked by monitor.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sdma_pkg::*;
    localparam logic [10:0] ERRB = 11'h071, OVRB = 11'h048, SSEL = 11'h006;
    localparam logic [10:0] FRMB = 11'h060, ULRA = 11'h080, ULTB = 11'h400;
    localparam logic [31:0] C0 = SER1_CTRL_ADDR, S0 = SER1_STATUS_ADDR;
    localparam logic [31:0] C1 = SER2_CTRL_ADDR, S1 = SER2_STATUS_ADDR;
    logic                    clk_i, reset_i, read_i, write_i, slow_reg;
    logic [31:0]             address_i, writedata_i, readdata_o;
    logic [3:0]              byteenable_i;
    logic                    waitrequest_o;
    sdma_evt_type [1:0]      evt_i, cmd_reg;
    sdma_chan_out_type [1:0] chan_o;
    logic [31:0]             exp_q[$];
    logic [31:0]             reset_addrs [5] =
        '{C0, S0, C1, S1, 32'h4000_C834};
    int                      mismatches, total_checks;
    sdma_ctrl DUT (.clk_i(clk_i), .reset_i(reset_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .evt_i(evt_i), .chan_o(chan_o));
    sdma_far_model far (.clk_i(clk_i), .reset_i(reset_i), .slow_i(slow_reg),
        .cmd_i(cmd_reg), .evt_o(evt_i));
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic compare(input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected at %0t: read %h, want %h", $time, g, e);
        end
    endtask
    always @(posedge clk_i)
        if (read_i && waitrequest_o === 1'b0)
            compare(exp_q.pop_front(), readdata_o);
    task automatic bus(input logic w, input logic [31:0] a, d,
                       input logic [3:0] be);
        @(posedge clk_i);
        read_i <= !w;
        write_i <= w;
        address_i <= a;
        writedata_i <= d;
        byteenable_i <= be;
        do
        begin
            @(posedge clk_i);
        end
        while (waitrequest_o !== 1'b0);
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [5:0] d);
        bus(1'b1, a, ({$urandom} << 6) | 32'(d), 4'h1 | 4'($urandom));
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    task automatic ev(input int i, input logic [10:0] e);
        @(posedge clk_i);
        cmd_reg[i] <= sdma_evt_type'(e);
        slow_reg <= 1'($urandom);
        @(posedge clk_i);
        cmd_reg <= '0;
        @(posedge clk_i);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        conclude();
    end
    initial
    begin
        void'($urandom(32'hC712_8E18));
        {read_i, write_i, slow_reg, reset_i} = 4'h1;
        {address_i, writedata_i, byteenable_i} = '0;
        cmd_reg = '0;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        foreach (reset_addrs[k])
            rd(reset_addrs[k], 32'h0);
        $display("test reset values done");
        wr(C0, 6'h03);
        rd(C0, 32'h3);
        rd(S0, 32'h1);
        wr(C1, 6'h10);
        rd(C0, 32'h3);
        $display("test loads done");
        ev(0, ERRB);
        rd(S0, 32'h141);
        wr(S0, 6'h3F);
        rd(S0, 32'h141);
        bus(1'b1, C0, 32'h20, 4'hE);
        rd(C0, 32'h3);
        ev(0, ULRA);
        rd(C0, 32'h2);
        rd(S0, 32'h142);
        wr(C0, 6'h00);
        rd(C0, 32'h2);
        $display("test errors and unload done");
        ev(0, SSEL);
        rd(S0, 32'hD42);
        ev(0, SSEL);
        rd(S0, 32'h1D42);
        ev(0, ERRB);
        ev(0, OVRB);
        rd(S0, 32'h1FE2);
        wr(C0, 6'h10);
        rd(C0, 32'h0);
        rd(S0, 32'h0);
        $display("test buffer B and reset done");
        wr(C0, 6'h01);
        ev(0, SSEL);
        rd(S0, 32'h801);
        wr(C0, 6'h02);
        rd(S0, 32'h1);
        rd(C0, 32'h3);
        ev(0, SSEL);
        ev(0, SSEL);
        rd(S0, 32'h1801);
        ev(0, FRMB);
        rd(S0, 32'h1801);
        wr(C1, 6'h01);
        ev(1, ERRB);
        rd(S1, 32'h1);
        $display("test count save done");
        wr(C0, 6'h08);
        wr(C0, 6'h04);
        rd(C0, 32'hF);
        rd(S0, 32'h1809);
        ev(0, ULTB);
        ev(0, ULTB);
        rd(C0, 32'h7);
        rd(S0, 32'h1805);
        wr(C0, 6'h20);
        rd(C0, 32'h3);
        rd(S0, 32'h1801);
        $display("test transmit done");
        repeat (3) @(posedge clk_i);
        conclude();
    end
endmodule
bind sdma_ctrl sdma_ctrl_chk chk (.clk_i(clk_i), .reset_i(reset_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .evt_i(evt_i), .chan_o(chan_o));
